/* File: rtl/wdt_map.svh */
// Register offsets, field positions, reset values and timing figures of the watchdog.
// Assumes inclusion by bare name from every file that decodes the map.
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define WDT_OFS_CURRENT_COUNT 8'h00
`define WDT_OFS_RELOAD_VALUE 8'h04
`define WDT_OFS_RESTART_KEY 8'h08
`define WDT_OFS_CONTROL 8'h0c
`define WDT_OFS_TIMEOUT_STATUS 8'h10
`define WDT_OFS_STATUS_CLEAR 8'h14
`define WDT_OFS_PULSE_LENGTH 8'h18
`define WDT_OFS_DESIGN_REVISION 8'h1c

// ==========================================================
// Control field positions
`define WDT_CTL_COUNT_ENABLE 0
`define WDT_CTL_SYSTEM_RESET_ENABLE 1
`define WDT_CTL_SYSTEM_INTERRUPT_ENABLE 2
`define WDT_CTL_EXTERNAL_SIGNAL_ENABLE 3
`define WDT_CTL_COUNT_CLOCK_SELECT 4
`define WDT_CTL_WIDTH 5

// ==========================================================
// Reset values and key
`define WDT_RST_COUNT 32'h03ef1480
`define WDT_RST_RELOAD 32'h03ef1480
`define WDT_RST_CONTROL 5'h00
`define WDT_RST_PULSE_LENGTH 8'hff
`define WDT_RESTART_KEY 16'h5ab9

// ==========================================================
// Timing: pulse lasts the programmed length plus this many cycles
`define WDT_PULSE_EXTRA 9'h001

`endif

/* File: rtl/wdt_pkg.sv */
// Types shared by the watchdog core and its pulse stretcher.
// Assumes wdt_map.svh is on the include path.
package wdt_pkg;

    // ==========================================================
    // Control register layout, msb first
    typedef struct packed {
        logic count_clock_select;
        logic external_signal_enable;
        logic system_interrupt_enable;
        logic system_reset_enable;
        logic count_enable;
    } wdt_control_t;

    // ==========================================================
    // Pulse stretcher states
    typedef enum logic [0:0] {
        WDT_PULSE_IDLE,
        WDT_PULSE_ACTIVE
    } wdt_pulse_state_t;

endpackage : wdt_pkg

/* File: rtl/wdt_pulse.sv */
// Pulse stretcher: holds an output high for length plus one core clock cycles.
// Assumes start is a one-cycle pulse synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module wdt_pulse
    import wdt_pkg::*;
#(
    parameter int LEN_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [LEN_W-1:0] length,
    output logic active
);

    wdt_pulse_state_t state_r;
    wdt_pulse_state_t state_nxt;
    logic [LEN_W:0] cnt_r;
    logic [LEN_W:0] cnt_nxt;

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            WDT_PULSE_IDLE: begin
                if (start) begin
                    state_nxt = WDT_PULSE_ACTIVE;
                    cnt_nxt = {1'b0, length};
                end
            end
            WDT_PULSE_ACTIVE: begin
                // Retrigger restarts the full length
                if (start) begin
                    cnt_nxt = {1'b0, length};
                end else if (cnt_r == '0) begin
                    state_nxt = WDT_PULSE_IDLE;
                end else begin
                    cnt_nxt = cnt_r - (LEN_W+1)'(`WDT_PULSE_EXTRA);
                end
            end
            default: begin
                state_nxt = WDT_PULSE_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= WDT_PULSE_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign active = (state_r == WDT_PULSE_ACTIVE);

endmodule : wdt_pulse
`default_nettype wire

/* File: rtl/wdt_top.sv */
// Watchdog timer: 32-bit down counter behind an APB slave, with timeout pulses.
// Assumes an APB master on core_clk and an external count clock synchronous to core_clk.
//
// How it works
// - Count resets to 0x3EF1480; software can only read it.
// - Bus writes to the count offset never change the count.
// - Count decrements on each selected tick while control bit 0 is set, and stops at zero.
// - With counting disabled the count holds; no decrement, no reload.
// - Reload register is RW, resets to 0x3EF1480, loaded on reset and restart.
// - Writing key 0x5AB9 to restart register reloads the count while control bit 0 is set; ignored otherwise.
// - Restart register returns to zero after each write cycle.
// - Control bit 4 picks bus clock (0) or external clock (1).
// - Control bit 3 enables the external timeout output.
// - Control bit 2 enables the system interrupt output.
// - Control bit 1 enables the system reset output.
// - Control is 5 bits, resets to zero, bit 0 enables counting.
// - Read-only timeout flag sets when the count reaches zero.
// - Timeout flag holds until cleared through the clear register.
// - Any write to the clear register clears the timeout flag, unless an expiry in the same cycle sets it.
// - Pulse length register, default 0xFF, gives value plus one cycles.
// - Read-only 32-bit revision register returns a fixed number.
// - At zero, every enabled timeout output is asserted.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module wdt_top
    import wdt_pkg::*;
#(
    parameter int COUNT_W = 32,
    parameter int LEN_W = 8,
    // Arbitrary revision value
    parameter logic [31:0] REVISION = 32'h0001_0203
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_clock,
    output logic timeout_reset_out,
    output logic timeout_interrupt_out,
    output logic timeout_external_out,
    output logic timeout_state_out
);

    // ==========================================================
    // Decode helper
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr[1:0] == 2'b00) && (addr <= `WDT_OFS_DESIGN_REVISION);
    endfunction : is_mapped

    function automatic logic wr_hit(input logic sel, input logic en, input logic wr,
                                    input logic [7:0] addr, input logic [7:0] ofs);
        wr_hit = sel && en && wr && (addr == ofs);
    endfunction : wr_hit

    // ==========================================================
    // State
    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] count_nxt;
    logic [COUNT_W-1:0] reload_r;
    logic [COUNT_W-1:0] reload_nxt;
    logic [15:0] restart_r;
    logic [15:0] restart_nxt;
    wdt_control_t control_r;
    wdt_control_t control_nxt;
    logic status_r;
    logic status_nxt;
    logic [LEN_W-1:0] length_r;
    logic [LEN_W-1:0] length_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic ext_prev_r;
    logic ext_prev_nxt;

    logic access;
    logic restart_go;
    logic tick;
    logic expiry;
    logic pulse_active;

    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && !is_mapped(paddr);

    // ==========================================================
    // Tick source
    always_comb begin
        ext_prev_nxt = external_count_clock;
    end

    always_comb begin
        // Rising edge of the external clock; needs it slower than half core_clk
        if (control_r.count_clock_select) begin
            tick = external_count_clock && !ext_prev_r;
        end else begin
            tick = 1'b1;
        end
    end

    // ==========================================================
    // Restart key register
    always_comb begin
        restart_nxt = 16'h0000;
        if (wr_hit(psel, penable, pwrite, paddr, `WDT_OFS_RESTART_KEY)) begin
            restart_nxt = pwdata[15:0];
        end
    end

    // Only the exact key counts, and only while enabled
    assign restart_go = (restart_r == `WDT_RESTART_KEY) && control_r.count_enable;

    // ==========================================================
    // Counter
    always_comb begin
        count_nxt = count_r;
        expiry = 1'b0;
        // No write path to count_r from the bus
        if (restart_go) begin
            count_nxt = reload_r;
        end else if (control_r.count_enable && tick && (count_r != '0)) begin
            count_nxt = count_r - COUNT_W'(1);
            // Fires on the step into zero only, so once per expiry
            expiry = (count_r == COUNT_W'(1));
        end
    end

    // ==========================================================
    // Configuration registers
    always_comb begin
        reload_nxt = reload_r;
        control_nxt = control_r;
        length_nxt = length_r;
        if (wr_hit(psel, penable, pwrite, paddr, `WDT_OFS_RELOAD_VALUE)) begin
            reload_nxt = pwdata[COUNT_W-1:0];
        end
        if (wr_hit(psel, penable, pwrite, paddr, `WDT_OFS_CONTROL)) begin
            control_nxt = pwdata[`WDT_CTL_WIDTH-1:0];
        end
        if (wr_hit(psel, penable, pwrite, paddr, `WDT_OFS_PULSE_LENGTH)) begin
            length_nxt = pwdata[LEN_W-1:0];
        end
    end

    // ==========================================================
    // Timeout status
    always_comb begin
        status_nxt = status_r;
        // Data value ignored; expiry in the same cycle wins
        if (wr_hit(psel, penable, pwrite, paddr, `WDT_OFS_STATUS_CLEAR)) begin
            status_nxt = 1'b0;
        end
        if (expiry) begin
            status_nxt = 1'b1;
        end
    end

    // ==========================================================
    // Read data, captured in the setup phase
    always_comb begin
        prdata_nxt = prdata_r;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `WDT_OFS_CURRENT_COUNT: prdata_nxt = 32'(count_r);
                `WDT_OFS_RELOAD_VALUE: prdata_nxt = 32'(reload_r);
                `WDT_OFS_CONTROL: prdata_nxt = 32'(control_r);
                `WDT_OFS_TIMEOUT_STATUS: prdata_nxt = {31'h0, status_r};
                `WDT_OFS_PULSE_LENGTH: prdata_nxt = 32'(length_r);
                `WDT_OFS_DESIGN_REVISION: prdata_nxt = REVISION;
                // Write-only and unmapped offsets read as zero
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= COUNT_W'(`WDT_RST_COUNT);
            reload_r <= COUNT_W'(`WDT_RST_RELOAD);
            restart_r <= 16'h0000;
            control_r <= `WDT_RST_CONTROL;
            status_r <= 1'b0;
            length_r <= LEN_W'(`WDT_RST_PULSE_LENGTH);
            prdata_r <= 32'h0000_0000;
            ext_prev_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            reload_r <= reload_nxt;
            restart_r <= restart_nxt;
            control_r <= control_nxt;
            status_r <= status_nxt;
            length_r <= length_nxt;
            prdata_r <= prdata_nxt;
            ext_prev_r <= ext_prev_nxt;
        end
    end

    assign prdata = prdata_r;

    // ==========================================================
    // Timeout pulses
    wdt_pulse #(
        .LEN_W(LEN_W)
    ) u_pulse (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(expiry),
        .length(length_r),
        .active(pulse_active)
    );

    // Enables gate the pulse live, so clearing one cuts its output at once
    assign timeout_state_out = pulse_active;
    assign timeout_reset_out = pulse_active && control_r.system_reset_enable;
    assign timeout_interrupt_out = pulse_active && control_r.system_interrupt_enable;
    assign timeout_external_out = pulse_active && control_r.external_signal_enable;

endmodule : wdt_top
`default_nettype wire

/* File: test/wdt_top_sva.sv */
// Port-level assertions for the watchdog top module.
// Assumes it is bound into wdt_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wdt_top_chk #(
    parameter logic [31:0] REVISION = 32'h0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic external_count_clock,
    input wire logic timeout_reset_out,
    input wire logic timeout_interrupt_out,
    input wire logic timeout_external_out,
    input wire logic timeout_state_out
);
    // ==========================================
    // Shadow of the pulse length and a run counter
    logic [7:0] len_r;
    logic [8:0] run_r;
    logic [4:0] ctl_r;
    logic acc;
    assign acc = psel && penable;
    // Retriggering mid-pulse is not covered by the run counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            len_r <= 8'hff;
            run_r <= 9'h000;
            ctl_r <= 5'h00;
        end else begin
            if (acc && pwrite && paddr == 8'h18) begin
                len_r <= pwdata[7:0];
            end
            // Shadow of the control word, so each output is held to its own enable
            if (acc && pwrite && paddr == 8'h0c) begin
                ctl_r <= pwdata[4:0];
            end
            run_r <= timeout_state_out ? run_r + 9'h001 : 9'h000;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_pulse_not_long: assert property (timeout_state_out |-> run_r <= {1'b0, len_r})
        else $error("pulse longer than length plus one");
    a_pulse_full_len: assert property ($fell(timeout_state_out) |-> run_r == {1'b0, len_r} + 9'h001)
        else $error("pulse ended early");
    a_reset_out_gated: assert property (timeout_reset_out == (timeout_state_out && ctl_r[1]))
        else $error("reset output does not follow pulse and enable");
    a_irq_out_gated: assert property (timeout_interrupt_out == (timeout_state_out && ctl_r[2]))
        else $error("interrupt output does not follow pulse and enable");
    a_ext_out_gated: assert property (timeout_external_out == (timeout_state_out && ctl_r[3]))
        else $error("external output does not follow pulse and enable");
    a_revision_read: assert property (acc && !pwrite && paddr == 8'h1c |-> prdata == REVISION)
        else $error("revision read wrong");
    a_wo_reads_zero: assert property (acc && !pwrite && (paddr == 8'h08 || paddr == 8'h14) |-> prdata == 32'h0)
        else $error("write-only register read nonzero");
    a_status_one_bit: assert property (acc && !pwrite && paddr == 8'h10 |-> prdata[31:1] == 31'h0)
        else $error("status upper bits set");
    a_unmapped_err: assert property (acc && paddr > 8'h1c |-> pslverr && pready)
        else $error("unmapped access not flagged");
    c_pulse: cover property ($rose(timeout_state_out));
    c_reset_only: cover property (timeout_reset_out && !timeout_interrupt_out);
    c_restart: cover property (acc && pwrite && paddr == 8'h08);
endmodule : wdt_top_chk
bind wdt_top wdt_top_chk #(.REVISION(REVISION)) u_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_clock(external_count_clock), .timeout_reset_out(timeout_reset_out),
    .timeout_interrupt_out(timeout_interrupt_out), .timeout_external_out(timeout_external_out),
    .timeout_state_out(timeout_state_out));
`default_nettype wire

/* File: test/watchdog_timer_test.sv */
// Self-checking bench for the watchdog top module.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_test;
    // ==========================================
    // Signals and counters
    localparam logic [31:0] REV = 32'h0000_0a5c; // Arbitrary value
    typedef struct packed { logic [7:0] a; logic [31:0] v; } wdt_row_t;
    wdt_row_t rows [8];
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, held;
    logic pready, pslverr, err, rst_o, irq_o, ext_o, st_o;
    int n_errors = 0, comparisons = 0, cycles = 0;
    always #5 core_clk = ~core_clk;
    wdt_top #(.REVISION(REV)) dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_clock(ext), .timeout_reset_out(rst_o), .timeout_interrupt_out(irq_o),
        .timeout_external_out(ext_o), .timeout_state_out(st_o));
    // ==========================================
    // Tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Inputs move on falling edges only
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk);
        psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(negedge core_clk);
        penable = 1'b1;
        @(negedge core_clk);
        rd = prdata;
        err = pslverr;
        psel = 1'b0;
        penable = 1'b0;
    endtask : bus
    task automatic rd_reg(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rd_reg
    task automatic wait_pulse();
        for (int i = 0; i < 300 && st_o !== 1'b1; i++) @(negedge core_clk);
        check("pulse start", 32'h1, {31'h0, st_o});
    endtask : wait_pulse
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end
    // ==========================================
    // Sequence
    initial begin
        rows = '{'{8'h00, 32'h03ef1480}, '{8'h04, 32'h03ef1480}, '{8'h08, 32'h0}, '{8'h0c, 32'h0},
            '{8'h10, 32'h0}, '{8'h14, 32'h0}, '{8'h18, 32'hff}, '{8'h1c, REV}};
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            rd_reg(rows[i].a);
            check("reset value", rows[i].v, rd);
        end
        bus(1'b1, 8'h00, 32'h55);
        bus(1'b1, 8'h04, 32'h20);
        bus(1'b1, 8'h08, 32'h5ab9);
        rd_reg(8'h00);
        check("count held", 32'h03ef1480, rd);
        bus(1'b1, 8'h18, 32'h3);
        bus(1'b1, 8'h0c, 32'hf);
        bus(1'b1, 8'h08, 32'h1234);
        rd_reg(8'h00);
        check("counting", 32'h1, {31'h0, rd > 32'h20 && rd < 32'h03ef1480});
        bus(1'b1, 8'h08, 32'h5ab9);
        rd_reg(8'h00);
        check("restarted", 32'h1, {31'h0, rd <= 32'h20 && rd > 32'h0});
        wait_pulse();
        check("all outputs", 32'hf, {28'h0, st_o, rst_o, irq_o, ext_o});
        rd_reg(8'h10);
        check("status set", 32'h1, rd);
        repeat (20) @(negedge core_clk);
        check("one pulse", 32'h0, {31'h0, st_o});
        rd_reg(8'h00);
        check("count at zero", 32'h0, rd);
        rd_reg(8'h10);
        check("status kept", 32'h1, rd);
        bus(1'b1, 8'h14, 32'h0);
        rd_reg(8'h10);
        check("status cleared", 32'h0, rd);
        bus(1'b1, 8'h0c, 32'h3);
        bus(1'b1, 8'h08, 32'h5ab9);
        wait_pulse();
        check("reset only", 32'hc, {28'h0, st_o, rst_o, irq_o, ext_o});
        bus(1'b1, 8'h08, 32'h5ab9);
        bus(1'b1, 8'h0c, 32'h0);
        rd_reg(8'h00);
        held = rd;
        repeat (5) @(negedge core_clk);
        rd_reg(8'h00);
        check("disabled hold", held, rd);
        bus(1'b1, 8'h04, 32'h5);
        bus(1'b1, 8'h0c, 32'h11);
        bus(1'b1, 8'h08, 32'h5ab9);
        repeat (2) begin
            repeat (2) @(negedge core_clk);
            ext = 1'b1;
            repeat (2) @(negedge core_clk);
            ext = 1'b0;
        end
        rd_reg(8'h00);
        check("external ticks", 32'h3, rd);
        // Reset in mid-run, while counting on the external clock
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        rd_reg(8'h00);
        check("count after reset", 32'h03ef1480, rd);
        rd_reg(8'h0c);
        check("control after reset", 32'h0, rd);
        rd_reg(8'h04);
        check("reload after reset", 32'h03ef1480, rd);
        rd_reg(8'h20);
        check("unmapped", 32'h1, {31'h0, err});
        final_report();
    end
endmodule : watchdog_timer_test
`default_nettype wire
